// File: core/tpc_timer.sv
// Prescaled 16-bit timer with match, capture and match pins
//
// Function
// - Registers decoded at listed offsets, gap reserved
// - All implemented register bits reset to zero
// - Five pending flags: matches 0-3, capture
// - Writing one clears a flag, zero ignored
// - Enable bit lets both counters advance
// - Reset bit clears counters until written zero
// - Divider reaching limit bumps timer, clears divider
// - Timer wraps at maximum without flag
// - Divider count readable and writable by software
// - Match compares: reset, stop, flag
// - Match control selects flag, reset and stop
// - Capture event loads timer count
// - Capture control selects edges and flag
// - Match output control drives three pins
// - Count source selects timer or counter mode
// - Pulse-width select puts pins in modulation
// - Match pins toggle, low, high or hold
`timescale 1ns/1ns
module tpc_timer
   import tpc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic capture_input_i,
   output logic [31:0] rdata_o,
   output logic [2:0] match_output_pins_o
);

   // ==========================================================
   // State
   // ==========================================================
   tpc_state_type s;
   tpc_state_type next_s;
   logic [3:0] hit;
   logic cnt_evt;
   logic cnt_go;
   logic tick;
   logic cap_rise;
   logic cap_fall;
   logic cap_evt;
   logic [31:0] rd_mux;
   logic [3:0] match_reset;
   logic [3:0] match_stop;

   assign rdata_o = s.rdata;
   assign match_output_pins_o = s.pins;

   // ==========================================================
   // Count source and edges
   // ==========================================================
   assign cap_rise = s.cap_sync & ~s.cap_prev;
   assign cap_fall = ~s.cap_sync & s.cap_prev;

   always_comb begin
      case (tpc_mode_type'(s.count_source_control[1:0]))
         TPC_MODE_TIMER: cnt_evt = 1'b1;
         TPC_MODE_RISE: cnt_evt = cap_rise;
         TPC_MODE_FALL: cnt_evt = cap_fall;
         TPC_MODE_BOTH: cnt_evt = cap_rise | cap_fall;
         default: cnt_evt = 1'b0;
      endcase
      if (s.count_source_control[1:0] != TPC_MODE_TIMER && s.count_source_control[3:2] != SRC_CAPTURE) begin
         cnt_evt = 1'b0;
      end
   end

   assign cnt_go = s.ctl[CTL_EN] & ~s.ctl[CTL_RST] & cnt_evt;
   assign tick = cnt_go & (s.pc == s.pr);

   assign cap_evt = (s.capture_edge_control[CCR_RISE] & cap_rise) |
                    (s.capture_edge_control[CCR_FALL] & cap_fall);

   // ==========================================================
   // Match compare per channel
   // ==========================================================
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_match
         assign hit[gi] = tick & (s.tc == s.mr[gi]);
         assign match_reset[gi] = hit[gi] & s.match_action_control[3*gi+MCR_RST];
         assign match_stop[gi] = hit[gi] & s.match_action_control[3*gi+MCR_STOP];
      end
   endgenerate

   // ==========================================================
   // Read decode
   // ==========================================================
   // Offset decode, reserved gap reads zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (addr_i)
         OFS_FLAGS: rd_mux = {27'h0, s.flags};
         OFS_CTL: rd_mux = {30'h0, s.ctl};
         OFS_TC: rd_mux = {16'h0, s.tc};
         OFS_PR: rd_mux = {16'h0, s.pr};
         OFS_PC: rd_mux = {16'h0, s.pc};
         OFS_MCR: rd_mux = {20'h0, s.match_action_control};
         OFS_MR0: rd_mux = {16'h0, s.mr[0]};
         OFS_MR1: rd_mux = {16'h0, s.mr[1]};
         OFS_MR2: rd_mux = {16'h0, s.mr[2]};
         OFS_MR3: rd_mux = {16'h0, s.mr[3]};
         OFS_CCR: rd_mux = {29'h0, s.capture_edge_control};
         OFS_CAP: rd_mux = {16'h0, s.cap};
         OFS_EMR: rd_mux = {20'h0, s.match_output_control};
         OFS_COUNT_SOURCE_CONTROL: rd_mux = {28'h0, s.count_source_control};
         OFS_PWM: rd_mux = {29'h0, s.pwm};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_s = s;
      next_s.cap_meta = capture_input_i;
      next_s.cap_sync = s.cap_meta;
      next_s.cap_prev = s.cap_sync;
      next_s.rdata = rd_i ? rd_mux : 32'h0000_0000;

      // Plain register writes
      if (wr_i) begin
         case (addr_i)
            OFS_CTL: next_s.ctl = wdata_i[1:0];
            OFS_PR: next_s.pr = wdata_i[15:0];
            OFS_MCR: next_s.match_action_control = wdata_i[11:0];
            OFS_MR0: next_s.mr[0] = wdata_i[15:0];
            OFS_MR1: next_s.mr[1] = wdata_i[15:0];
            OFS_MR2: next_s.mr[2] = wdata_i[15:0];
            OFS_MR3: next_s.mr[3] = wdata_i[15:0];
            OFS_CCR: next_s.capture_edge_control = wdata_i[2:0];
            OFS_EMR: next_s.match_output_control = wdata_i[11:0];
            OFS_COUNT_SOURCE_CONTROL: next_s.count_source_control = wdata_i[3:0];
            OFS_PWM: next_s.pwm = wdata_i[2:0];
            default: next_s.ctl = next_s.ctl;
         endcase
      end

      if (wr_i && addr_i == OFS_FLAGS) begin
         next_s.flags = s.flags & ~wdata_i[4:0];
      end

      if (cnt_go) begin
         next_s.pc = tick ? 16'h0000 : 16'(s.pc + 16'h0001);
      end
      if (tick) begin
         next_s.tc = 16'(s.tc + 16'h0001);
      end
      if (|match_reset) begin
         next_s.tc = 16'h0000;
      end
      if (|match_stop) begin
         next_s.ctl[CTL_EN] = 1'b0;
      end

      if (wr_i && addr_i == OFS_TC) begin
         next_s.tc = wdata_i[15:0];
      end
      if (wr_i && addr_i == OFS_PC) begin
         next_s.pc = wdata_i[15:0];
      end

      if (next_s.ctl[CTL_RST]) begin
         next_s.tc = 16'h0000;
         next_s.pc = 16'h0000;
      end

      // Per-channel flags and pin actions
      for (int i = 0; i < 4; i++) begin
         if (hit[i] && s.match_action_control[3*i+MCR_INT]) begin
            next_s.flags[i] = 1'b1;
         end
         if (hit[i]) begin
            case (s.match_output_control[EMR_ACT+2*i +: 2])
               ACT_LOW: next_s.match_output_control[i] = 1'b0;
               ACT_HIGH: next_s.match_output_control[i] = 1'b1;
               ACT_TOGGLE: next_s.match_output_control[i] = ~s.match_output_control[i];
               default: next_s.match_output_control[i] = next_s.match_output_control[i];
            endcase
         end
      end

      if (cap_evt) begin
         next_s.cap = s.tc;
      end
      if (cap_evt && s.capture_edge_control[CCR_INT]) begin
         next_s.flags[FLAG_CAP] = 1'b1;
      end

      // Pins from match state or modulation
      for (int j = 0; j < 3; j++) begin
         next_s.pins[j] = s.pwm[j] ? (s.tc >= s.mr[j]) : next_s.match_output_control[j];
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= TPC_STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   logic cap_int_evt;
   assign cap_int_evt = cap_evt & s.capture_edge_control[CCR_INT];

   flag_priority_a: assert property (
      (hit[0] && s.match_action_control[MCR_INT] && wr_i && addr_i == OFS_FLAGS &&
       wdata_i[0]) |=> s.flags[0])
      else $error("Match flag lost to clear");

   flag_clear_a: assert property (
      (wr_i && addr_i == OFS_FLAGS && wdata_i[FLAG_CAP] && !cap_int_evt)
      |=> !s.flags[FLAG_CAP])
      else $error("Capture flag not cleared");

   flag_width_a: assert property (
      (rd_i && addr_i == OFS_FLAGS) |=> (rdata_o[31:5] == 27'h0 &&
       rdata_o[4:0] == $past(s.flags)))
      else $error("Flag read wrong");

   hold_disabled_a: assert property (
      (!s.ctl[CTL_EN] && !wr_i) |=> ($stable(s.tc) && $stable(s.pc)))
      else $error("Counter moved while disabled");

   ctl_reset_a: assert property (
      (s.ctl[CTL_RST] && s.ctl[CTL_EN]) [*2] |-> (s.tc == 16'h0000 &&
       s.pc == 16'h0000))
      else $error("Counter not held in reset");

   prescale_step_a: assert property (
      (tick && !wr_i && !(|match_reset) && !next_s.ctl[CTL_RST]) |=>
      (s.pc == 16'h0000 && s.tc == 16'($past(s.tc) + 16'h0001)))
      else $error("Timer did not step at terminal count");

   wrap_quiet_a: assert property (
      (tick && s.tc == 16'hffff && !wr_i && !(|hit) && !cap_int_evt &&
       !s.ctl[CTL_RST]) |=> (s.tc == 16'h0000 && $stable(s.flags)))
      else $error("Wrap misbehaved");

   pc_write_a: assert property (
      (wr_i && addr_i == OFS_PC && !s.ctl[CTL_RST])
      |=> s.pc == $past(wdata_i[15:0]))
      else $error("Divider write lost");

   capture_load_a: assert property (
      cap_evt |=> s.cap == $past(s.tc))
      else $error("Capture value wrong");

   match_stop_a: assert property (
      (|match_stop && !(wr_i && addr_i == OFS_CTL)) |=> ##1
      $stable(s.pc))
      else $error("Stop on match failed");

   pin_toggle_a: assert property (
      (hit[1] && s.match_output_control[EMR_ACT+2 +: 2] == ACT_TOGGLE && !s.pwm[1] &&
       !wr_i) |=> (match_output_pins_o[1] != $past(s.match_output_control[1])))
      else $error("Match pin did not toggle");

   reserved_read_a: assert property (
      (rd_i && addr_i >= OFS_RSV_LO && addr_i <= OFS_RSV_HI) |=>
      (rdata_o == 32'h0000_0000))
      else $error("Reserved read not zero");

   rdata_idle_a: assert property (
      !rd_i |=> (rdata_o == 32'h0000_0000))
      else $error("Read data stood too long");

   flag_keep_a: assert property (
      (wr_i && addr_i == OFS_FLAGS && !wdata_i[2] && s.flags[2]) |=>
      s.flags[2])
      else $error("Flag cleared by zero");

   match_reset_a: assert property (
      ((|match_reset) && !(wr_i && addr_i == OFS_TC)) |=>
      (s.tc == 16'h0000))
      else $error("Timer not reset on match");

   stop_clear_a: assert property (
      (|match_stop) |=> !s.ctl[CTL_EN])
      else $error("Enable kept after stop");

   match_flag_a: assert property (
      (hit[1] && s.match_action_control[3+MCR_INT]) |=> s.flags[1])
      else $error("Match flag not set");

   cap_read_only_a: assert property (
      (wr_i && addr_i == OFS_CAP && !cap_evt) |=> $stable(s.cap))
      else $error("Capture value written");

   capture_flag_a: assert property (
      cap_int_evt |=> s.flags[FLAG_CAP])
      else $error("Capture flag not set");

   count_edge_a: assert property (
      (s.count_source_control[1:0] != TPC_MODE_TIMER && !cap_rise && !cap_fall) |->
      !tick)
      else $error("Counted without an edge");

   pwm_level_a: assert property (
      s.pwm[0] |=> (match_output_pins_o[0] ==
      ($past(s.tc) >= $past(s.mr[0]))))
      else $error("Modulated pin wrong");

   reset_wins_a: assert property (
      (s.ctl[CTL_EN] && s.ctl[CTL_RST] && !wr_i) |=>
      (s.tc == 16'h0000 && s.pc == 16'h0000))
      else $error("Enable beat reset bit");

   cov_wrap_c: cover property (tick && s.tc == 16'hffff);
   cov_match_c: cover property (|match_reset ##[1:20] tick);
   cov_capture_c: cover property (cap_int_evt);
   cov_counter_c: cover property (tick && s.count_source_control[1:0] != TPC_MODE_TIMER);
   cov_set_clear_c: cover property (hit[0] && wr_i && addr_i == OFS_FLAGS);

endmodule

// File: core/tpc_pkg.sv
// Constants and state type for the prescaled 16-bit timer
package tpc_pkg;

   // ==========================================================
   // Bus and register offsets
   // ==========================================================
   localparam int ADDR_W = 8;
   localparam logic [31:0] BASE_ADDR = 32'h4000_c000;
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_CTL = 8'h04;
   localparam logic [7:0] OFS_TC = 8'h08;
   localparam logic [7:0] OFS_PR = 8'h0c;
   localparam logic [7:0] OFS_PC = 8'h10;
   localparam logic [7:0] OFS_MCR = 8'h14;
   localparam logic [7:0] OFS_MR0 = 8'h18;
   localparam logic [7:0] OFS_MR1 = 8'h1c;
   localparam logic [7:0] OFS_MR2 = 8'h20;
   localparam logic [7:0] OFS_MR3 = 8'h24;
   localparam logic [7:0] OFS_CCR = 8'h28;
   localparam logic [7:0] OFS_CAP = 8'h2c;
   localparam logic [7:0] OFS_EMR = 8'h3c;
   localparam logic [7:0] OFS_RSV_LO = 8'h40;
   localparam logic [7:0] OFS_RSV_HI = 8'h6c;
   localparam logic [7:0] OFS_COUNT_SOURCE_CONTROL = 8'h70;
   localparam logic [7:0] OFS_PWM = 8'h74;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTL_EN = 0;
   localparam int CTL_RST = 1;
   localparam int FLAG_CAP = 4;
   localparam int MCR_INT = 0;
   localparam int MCR_RST = 1;
   localparam int MCR_STOP = 2;
   localparam int CCR_RISE = 0;
   localparam int CCR_FALL = 1;
   localparam int CCR_INT = 2;
   localparam int EMR_ACT = 4;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] SRC_CAPTURE = 2'h0;

   typedef enum logic [1:0] {
      TPC_MODE_TIMER = 2'b00,
      TPC_MODE_RISE = 2'b01,
      TPC_MODE_FALL = 2'b10,
      TPC_MODE_BOTH = 2'b11
   } tpc_mode_type;

   // ==========================================================
   // State and reset value
   // ==========================================================
   typedef struct packed {
      logic [4:0] flags;
      logic [1:0] ctl;
      logic [15:0] tc;
      logic [15:0] pr;
      logic [15:0] pc;
      logic [11:0] match_action_control;
      logic [3:0][15:0] mr;
      logic [2:0] capture_edge_control;
      logic [15:0] cap;
      logic [11:0] match_output_control;
      logic [3:0] count_source_control;
      logic [2:0] pwm;
      logic [2:0] pins;
      logic cap_meta;
      logic cap_sync;
      logic cap_prev;
      logic [31:0] rdata;
   } tpc_state_type;

   localparam tpc_state_type TPC_STATE_RESET = '0;

endpackage

// File: tb/tpc_cpu_model.sv
// Processor core model driving the timer register port
`timescale 1ns/1ns
module tpc_cpu_model
   import tpc_pkg::*;
(
   input wire logic sys_clk_i,
   output logic [ADDR_W-1:0] addr_o,
   output logic [31:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // ==========================================================
   // Idle bus
   // ==========================================================
   initial begin
      addr_o = '0;
      wdata_o = '0;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // ==========================================================
   // Bus cycles
   // ==========================================================
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      v = d;
      if (a == OFS_CTL) v = d & 32'h0000_0003;
      @(posedge sys_clk_i);
      addr_o <= a;
      wdata_o <= v;
      wr_o <= 1'b1;
      @(posedge sys_clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~v;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge sys_clk_i);
      rd_o <= 1'b0;
   endtask
endmodule

// File: tb/tpc_timer_tb.sv
// Self-checking bench for the prescaled 16-bit timer
`timescale 1ns/1ns
module tpc_timer_tb
   import tpc_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cap_in = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic rd_q = 1'b0;
   logic [31:0] rdata;
   logic [2:0] pins;
   logic [31:0] exp_q[$];
   logic [2:0] exp_p[$];
   logic pin_req = 1'b0;
   logic [31:0] d;
   logic [7:0] ofs [18] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h3c, 8'h70, 8'h74,
      8'h40, 8'h6c, 8'h30};
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   always #20 sys_clk_i = ~sys_clk_i;

   tpc_cpu_model u_tpc_cpu_model (.sys_clk_i(sys_clk_i), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

   tpc_timer u_tpc_timer (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .capture_input_i(cap_in), .rdata_o(rdata),
      .match_output_pins_o(pins));

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] v);
      u_tpc_cpu_model.wr(a, v);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      u_tpc_cpu_model.rd(a);
   endtask

   task automatic pk(input logic [2:0] e);
      exp_p.push_back(e);
      pin_req <= 1'b1;
      @(posedge sys_clk_i);
      pin_req <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // ==========================================================
   // Read watcher and timeout
   // ==========================================================
   always @(posedge sys_clk_i) begin
      if (rd_q && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
      if (pin_req && exp_p.size() > 0) begin
         chk({29'h0, pins}, {29'h0, exp_p.pop_front()});
      end
      rd_q <= rd;
   end

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      void'($urandom(7));
      cyc(5);
      rst_i <= 1'b0;
      foreach (ofs[i]) rc(ofs[i], 32'h0);
      w(8'h40, $urandom);
      rc(8'h40, 32'h0);
      $display("test reset values done");
      for (int i = 2; i < 10; i++) begin
         if (i == 5) continue;
         d = $urandom;
         w(8'(4 * i), d);
         rc(8'(4 * i), {16'h0, d[15:0]});
      end
      $display("test read write done");
      w(OFS_PR, 32'h3);
      w(OFS_PC, 32'h0);
      w(OFS_TC, 32'hffff);
      w(OFS_CTL, 32'h1);
      cyc(20);
      w(OFS_CTL, 32'h0);
      rc(OFS_TC, 32'h4);
      rc(OFS_FLAGS, 32'h0);
      cyc(10);
      rc(OFS_TC, 32'h4);
      $display("test prescale wrap done");
      w(OFS_CTL, 32'h3);
      cyc(5);
      rc(OFS_TC, 32'h0);
      rc(OFS_PC, 32'h0);
      rc(OFS_CTL, 32'h3);
      w(OFS_CTL, 32'h0);
      $display("test counter reset done");
      w(OFS_PR, 32'h0);
      for (int i = 0; i < 4; i++) begin
         w(OFS_TC, 32'h0);
         w(OFS_MR0 + 8'(4 * i), 32'h3);
         w(OFS_MCR, 32'h1 << (3 * i));
         w(OFS_CTL, 32'h1);
         cyc(8);
         w(OFS_CTL, 32'h0);
         rc(OFS_FLAGS, 32'h1 << i);
         w(OFS_FLAGS, 32'h0);
         rc(OFS_FLAGS, 32'h1 << i);
         w(OFS_FLAGS, 32'h1 << i);
         rc(OFS_FLAGS, 32'h0);
      end
      w(OFS_TC, 32'h0);
      w(OFS_MCR, 32'h5);
      w(OFS_CTL, 32'h1);
      cyc(20);
      rc(OFS_CTL, 32'h0);
      w(OFS_MCR, 32'h1);
      w(OFS_TC, 32'h0);
      w(OFS_FLAGS, 32'h1);
      w(OFS_CTL, 32'h1);
      w(OFS_FLAGS, 32'h1);
      w(OFS_FLAGS, 32'h1);
      w(OFS_CTL, 32'h0);
      rc(OFS_FLAGS, 32'h1);
      $display("test match flags done");
      w(OFS_MCR, 32'h0);
      w(OFS_FLAGS, 32'h1f);
      w(OFS_TC, 32'h1234);
      w(OFS_CCR, 32'h5);
      @(posedge sys_clk_i) cap_in <= 1'b1;
      cyc(6);
      rc(OFS_CAP, 32'h1234);
      rc(OFS_FLAGS, 32'h10);
      w(OFS_CAP, 32'h55);
      w(OFS_TC, 32'h0777);
      @(posedge sys_clk_i) cap_in <= 1'b0;
      cyc(6);
      rc(OFS_CAP, 32'h1234);
      $display("test capture done");
      w(OFS_CCR, 32'h0);
      w(OFS_PC, 32'h0);
      for (int m = 1; m < 4; m++) begin
         w(OFS_TC, 32'h0);
         w(OFS_COUNT_SOURCE_CONTROL, 32'(m));
         w(OFS_CTL, 32'h1);
         repeat (3) begin
            @(posedge sys_clk_i) cap_in <= 1'b1;
            cyc(4);
            @(posedge sys_clk_i) cap_in <= 1'b0;
            cyc(4);
         end
         w(OFS_CTL, 32'h0);
         rc(OFS_TC, (m == 3) ? 32'h6 : 32'h3);
      end
      w(OFS_COUNT_SOURCE_CONTROL, 32'h0);
      $display("test counter mode done");
      w(OFS_TC, 32'h0);
      w(OFS_EMR, 32'h20);
      w(OFS_CTL, 32'h1);
      cyc(10);
      w(OFS_CTL, 32'h0);
      pk(3'h1);
      rc(OFS_EMR, 32'h21);
      w(OFS_PWM, 32'h1);
      cyc(3);
      pk(3'h1);
      w(OFS_TC, 32'h0);
      cyc(3);
      pk(3'h0);
      $display("test match pins done");
      w(OFS_PWM, 32'h0);
      w(OFS_EMR, 32'hc0);
      w(OFS_MR1, 32'h4);
      w(OFS_MCR, 32'h10);
      w(OFS_CTL, 32'h1);
      cyc(5);
      w(OFS_CTL, 32'h0);
      rc(OFS_TC, 32'h2);
      pk(3'h2);
      $display("test match reset done");
      cyc(3);
      end_sim();
   end
endmodule
